// File: block_sync.sv
`timescale 1ns/1ps
`include "link_fault_params.svh"

module block_sync
#(
   parameter int GOOD_HDRS = `SYNC_GOOD_HDRS,
   parameter int BAD_LIMIT = `SYNC_BAD_LIMIT,
   parameter int WINDOW    = `SYNC_WINDOW
)
(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // Header stream and lock result
   sync_if.fsm       bus
);

   localparam int CW = $clog2((GOOD_HDRS > WINDOW ? GOOD_HDRS : WINDOW) + 1);

   fault_pkg::sync_state_e state, next_state;  // Sync machine
   logic [CW-1:0]          cnt, next_cnt;      // Good run or window
   logic [CW-1:0]          bad, next_bad;      // Bad headers in window

   assign bus.state      = state;
   assign bus.block_lock = (state == fault_pkg::SYNC_LOCK);

   ////////////////////////////////////////////////////////////////////////
   // Next state; losing the signal overrides every state transition
   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      next_bad   = bad;
      unique case (state)
         fault_pkg::SYNC_LOSS:
         begin
            next_cnt = '0;
            next_bad = '0;
            if (bus.sig_ok)
            begin
               next_state = fault_pkg::SYNC_HUNT;
            end
         end
         fault_pkg::SYNC_HUNT:
         begin
            // A run of good headers is needed; one bad restarts it
            if (bus.hdr_stb && !bus.hdr_ok)
            begin
               next_cnt = '0;
            end
            else if (bus.hdr_stb && cnt == CW'(GOOD_HDRS - 1))
            begin
               next_state = fault_pkg::SYNC_LOCK;
               next_cnt   = '0;
            end
            else if (bus.hdr_stb)
            begin
               next_cnt = cnt + 1'b1;
            end
         end
         fault_pkg::SYNC_LOCK:
         begin
            // Too many bad headers inside one window drops the lock
            if (bus.hdr_stb && !bus.hdr_ok && bad == CW'(BAD_LIMIT - 1))
            begin
               next_state = fault_pkg::SYNC_HUNT;
               next_cnt   = '0;
               next_bad   = '0;
            end
            else if (bus.hdr_stb && cnt == CW'(WINDOW - 1))
            begin
               next_cnt = '0;
               next_bad = '0;
            end
            else if (bus.hdr_stb)
            begin
               next_cnt = cnt + 1'b1;
               next_bad = bad + CW'(!bus.hdr_ok);
            end
         end
      endcase
      if (!bus.sig_ok)
      begin
         next_state = fault_pkg::SYNC_LOSS;
      end
   end

   // State registers
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= fault_pkg::SYNC_LOSS;
         cnt   <= '0;
         bad   <= '0;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
         bad   <= next_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   property p_loss_hold;
      !bus.sig_ok |=> state == fault_pkg::SYNC_LOSS;
   endproperty
   a_loss_hold: assert property (p_loss_hold)
      else $error("sync left loss state without signal");

   property p_lock_entry;
      $rose(bus.block_lock) |-> $past(state) == fault_pkg::SYNC_HUNT
                                && $past(bus.sig_ok);
   endproperty
   a_lock_entry: assert property (p_lock_entry)
      else $error("lock reached without hunting with signal");

endmodule : block_sync

// File: fault_pkg.sv
package fault_pkg;

   // Receive block synchronisation states
   typedef enum logic [1:0] {SYNC_LOSS, SYNC_HUNT, SYNC_LOCK} sync_state_e;

endpackage : fault_pkg

// File: link_fault_params.svh
`ifndef LINK_FAULT_PARAMS_SVH
`define LINK_FAULT_PARAMS_SVH

// Register byte offsets, one aligned word each
`define REG_STATUS_OFS      4'h0
`define REG_CONTROL_OFS     4'h4
`define REG_INT_STATUS_OFS  4'h8
`define REG_INT_MASK_OFS    4'hC

// Status register bit positions
`define ST_LINK_NOW         0
`define ST_LINK_LATCH       1
`define ST_FAULT_NOW        2
`define ST_FAULT_LATCH      3
`define ST_REMOTE           4
`define ST_BLOCK_LOCK       5
`define ST_HI_BER           6
`define ST_SIG_DET          7

// Control register bit positions (write one, self clearing)
`define CTL_CLR_LINK        0
`define CTL_CLR_FAULT       1
`define CTL_PCS_RESET       2

// Interrupt status and mask bit positions
`define INT_FAULT           0
`define INT_LINK_DOWN       1
`define INT_REMOTE          2
`define INT_WIDTH           3

// Reset values
`define INT_MASK_RST        3'h0
`define INT_STATUS_RST      3'h0
`define LINK_LATCH_RST      1'b0
`define FAULT_LATCH_RST     1'b0

// Fault sequence ordered set encoding
`define FLT_SEQ_CODE        8'h9C
`define FLT_CODE_LOCAL      8'h01
`define FLT_CODE_REMOTE     8'h02
`define FLT_CTRL            4'h1

// Block synchronisation counts, in sync headers
`define SYNC_GOOD_HDRS      64
`define SYNC_BAD_LIMIT      16
`define SYNC_WINDOW         64

`endif

// File: link_fault_signalling.sv
`timescale 1ns/1ps
`include "link_fault_params.svh"

module link_fault_signalling
#(
   parameter int GOOD_HDRS = `SYNC_GOOD_HDRS,
   parameter int BAD_LIMIT = `SYNC_BAD_LIMIT,
   parameter int WINDOW    = `SYNC_WINDOW
)
(
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   // Avalon-MM register slave
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output      logic [31:0] AVS_READDATA_O,
   output      logic        AVS_WAITREQUEST_O,
   // Decoded receive stream and its checks, same clock
   input  wire logic [31:0] RX_DATA_I,
   input  wire logic [3:0]  RX_CTRL_I,
   input  wire logic        HDR_STB_I,
   input  wire logic        HDR_OK_I,
   input  wire logic        HI_BER_I,
   input  wire logic        EBUF_ERR_I,
   // Transceiver and optics status pins, foreign timing
   input  wire logic        XCVR_LOCKED_I,
   input  wire logic        XCVR_RX_RST_DONE_I,
   input  wire logic        SIGNAL_DETECT_I,
   // Receive XGMII toward the MAC
   output      logic [31:0] XGMII_RXD_O,
   output      logic [3:0]  XGMII_RXC_O,
   // Immediate indications and interrupt
   output      logic        LINK_UP_O,
   output      logic        LOCAL_FAULT_O,
   output      logic        BLOCK_LOCK_O,
   output      logic        IRQ_O
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]            pin_meta;     // First synchroniser stage
   logic [2:0]            pin_sync;     // Second synchroniser stage
   logic                  ack;          // Bus request answered this cycle
   logic                  pcs_rst;      // Soft PCS reset pulse
   logic                  link_latch;   // Latched low link status
   logic                  fault_latch;  // Latched high local fault
   logic                  remote_seen;  // Remote fault, last cycle
   logic                  fault_q;      // Fault, last cycle
   logic                  link_q;       // Link, last cycle
   logic [`INT_WIDTH-1:0] int_st;       // Sticky interrupt causes
   logic [`INT_WIDTH-1:0] int_mask;     // Interrupt enables
   logic [31:0]           status_word;  // Packed status for reads
   logic [31:0]           rd_mux;       // Selected read word

   sync_if sif ();

   ////////////////////////////////////////////////////////////////////////
   // Status pins come from the transceiver and optics; two flops first
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end
      else
      begin
         pin_meta <= {SIGNAL_DETECT_I, XCVR_RX_RST_DONE_I, XCVR_LOCKED_I};
         pin_sync <= pin_meta;
      end
   end

   // Transceiver usable: locked and out of its receive reset
   wire xcvr_ok = pin_sync[0] & pin_sync[1];
   // Soft reset or an unusable transceiver looks like a lost signal, so
   // sync restarts cleanly and the link reads down until it relocks
   wire sig_ok  = pin_sync[2] & xcvr_ok & ~pcs_rst;

   ////////////////////////////////////////////////////////////////////////
   // Block synchronisation
   assign sif.hdr_stb = HDR_STB_I;
   assign sif.hdr_ok  = HDR_OK_I;
   assign sif.sig_ok  = sig_ok;

   block_sync
   #(
      .GOOD_HDRS (GOOD_HDRS),
      .BAD_LIMIT (BAD_LIMIT),
      .WINDOW    (WINDOW)
   )
   u_sync
   (
      .mclk_i  (MCLK_I),
      .rst_n_i (RST_N_I),
      .bus     (sif.fsm)
   );

   wire blk = sif.block_lock;

   ////////////////////////////////////////////////////////////////////////
   // Receiver readiness and link
   // Any cause of an unusable receiver raises the local fault
   wire fault_now = ~xcvr_ok | ~blk | HI_BER_I | EBUF_ERR_I | pcs_rst;
   // Link needs signal and block lock, and no high error rate
   wire link_now  = sig_ok & blk & ~HI_BER_I;

   // Local fault ordered set: 9C control on lane 0, code on lane 3
   wire [31:0] lf_word = {`FLT_CODE_LOCAL, 16'h0000, `FLT_SEQ_CODE};
   wire [31:0] rf_word = {`FLT_CODE_REMOTE, 16'h0000, `FLT_SEQ_CODE};

   // Remote fault from the far end, told apart by its lane 3 code
   wire rx_remote  = (RX_CTRL_I == `FLT_CTRL) && (RX_DATA_I == rf_word);
   wire remote_now = ~fault_now & rx_remote;

   // Fault replaces the stream; otherwise everything passes untouched
   wire [31:0] next_rxd = fault_now ? lf_word : RX_DATA_I;
   wire [3:0]  next_rxc = fault_now ? `FLT_CTRL : RX_CTRL_I;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   // One wait state: the answer comes in the cycle after the request
   wire req        = AVS_READ_I | AVS_WRITE_I;
   wire do_rd      = AVS_READ_I & ack;
   wire do_wr      = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
   wire sel_status = (AVS_ADDRESS_I == `REG_STATUS_OFS);
   wire sel_ctl    = (AVS_ADDRESS_I == `REG_CONTROL_OFS);
   wire sel_int    = (AVS_ADDRESS_I == `REG_INT_STATUS_OFS);
   wire sel_mask   = (AVS_ADDRESS_I == `REG_INT_MASK_OFS);
   wire ctl_wr     = do_wr & sel_ctl;
   wire rd_status  = do_rd & sel_status;
   wire rd_int     = do_rd & sel_int;

   assign AVS_WAITREQUEST_O = req & ~ack;

   ////////////////////////////////////////////////////////////////////////
   // Latch clears
   // A read clears only what that read reported, so an event landing
   // between the data snapshot and the clear is never lost
   wire clr_fault = (ctl_wr & AVS_WRITEDATA_I[`CTL_CLR_FAULT]) | pcs_rst
                  | (rd_status & AVS_READDATA_O[`ST_FAULT_LATCH]);
   wire reload_link = (ctl_wr & AVS_WRITEDATA_I[`CTL_CLR_LINK]) | pcs_rst
                    | (rd_status & ~AVS_READDATA_O[`ST_LINK_LATCH]);

   // Fault latch: set wins over clear
   wire next_fault_latch = fault_now | (fault_latch & ~clr_fault);
   // Link latch holds a drop; a reload takes the present level
   wire next_link_latch  = link_now & (link_latch | reload_link);

   ////////////////////////////////////////////////////////////////////////
   // Interrupt causes: fault rising, link falling, remote fault arriving
   wire [`INT_WIDTH-1:0] evt = {remote_now & ~remote_seen,
                                ~link_now & link_q,
                                fault_now & ~fault_q};
   wire [`INT_WIDTH-1:0] int_clr = rd_int ?
                                   AVS_READDATA_O[`INT_WIDTH-1:0] :
                                   {`INT_WIDTH{1'b0}};
   wire [`INT_WIDTH-1:0] next_int_st = evt | (int_st & ~int_clr);

   ////////////////////////////////////////////////////////////////////////
   // Read data selection; unmapped offsets read as zero
   always_comb
   begin
      status_word                  = 32'h0;
      status_word[`ST_LINK_NOW]    = link_now;
      status_word[`ST_LINK_LATCH]  = link_latch;
      status_word[`ST_FAULT_NOW]   = fault_now;
      status_word[`ST_FAULT_LATCH] = fault_latch;
      status_word[`ST_REMOTE]      = remote_seen;
      status_word[`ST_BLOCK_LOCK]  = blk;
      status_word[`ST_HI_BER]      = HI_BER_I;
      status_word[`ST_SIG_DET]     = pin_sync[2];
   end

   assign rd_mux = sel_status ? status_word :
                   sel_int    ? {29'h0, int_st} :
                   sel_mask   ? {29'h0, int_mask} : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake and read capture; data stands while ack is high
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ack            <= 1'b0;
         AVS_READDATA_O <= 32'h0;
      end
      else
      begin
         ack <= req & ~ack;
         if (AVS_READ_I && !ack)
         begin
            AVS_READDATA_O <= rd_mux;
         end
      end
   end

   // Control pulses and mask register
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pcs_rst  <= 1'b0;
         int_mask <= `INT_MASK_RST;
      end
      else
      begin
         pcs_rst <= ctl_wr & AVS_WRITEDATA_I[`CTL_PCS_RESET];
         if (do_wr && sel_mask)
         begin
            int_mask <= AVS_WRITEDATA_I[`INT_WIDTH-1:0];
         end
      end
   end

   // Latches, edge history and interrupt state
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         fault_latch <= `FAULT_LATCH_RST;
         link_latch  <= `LINK_LATCH_RST;
         remote_seen <= 1'b0;
         fault_q     <= 1'b1; // Fault is up out of reset: no false rise
         link_q      <= 1'b0;
         int_st      <= `INT_STATUS_RST;
         IRQ_O       <= 1'b0;
      end
      else
      begin
         fault_latch <= next_fault_latch;
         link_latch  <= next_link_latch;
         remote_seen <= remote_now;
         fault_q     <= fault_now;
         link_q      <= link_now;
         int_st      <= next_int_st;
         IRQ_O       <= |(int_st & int_mask);
      end
   end

   // Outputs toward the MAC, all from flops
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         XGMII_RXD_O   <= {`FLT_CODE_LOCAL, 16'h0000, `FLT_SEQ_CODE};
         XGMII_RXC_O   <= `FLT_CTRL;
         LINK_UP_O     <= 1'b0;
         LOCAL_FAULT_O <= 1'b1;
         BLOCK_LOCK_O  <= 1'b0;
      end
      else
      begin
         XGMII_RXD_O   <= next_rxd;
         XGMII_RXC_O   <= next_rxc;
         LINK_UP_O     <= link_now;
         LOCAL_FAULT_O <= fault_now;
         BLOCK_LOCK_O  <= blk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_lane0_start;
      fault_now |=> XGMII_RXC_O[0] && XGMII_RXD_O[7:0] == `FLT_SEQ_CODE;
   endproperty
   a_lane0_start: assert property (p_lane0_start)
      else $error("fault set does not open with 9C control");

   property p_two_forms;
      fault_now ##1 (!fault_now && !clr_fault)
         |=> fault_latch && !LOCAL_FAULT_O;
   endproperty
   a_two_forms: assert property (p_two_forms)
      else $error("latched fault did not outlive immediate fault");

   property p_link_held;
      (!link_latch && !reload_link) |=> !link_latch;
   endproperty
   a_link_held: assert property (p_link_held)
      else $error("latched link rose without a clear");

   property p_emit_lf;
      fault_now |=> XGMII_RXD_O == lf_word && XGMII_RXC_O == `FLT_CTRL
                    && LOCAL_FAULT_O && fault_latch;
   endproperty
   a_emit_lf: assert property (p_emit_lf)
      else $error("local fault not sent or reported");

   property p_causes;
      (!xcvr_ok || !blk || HI_BER_I || EBUF_ERR_I) |=> LOCAL_FAULT_O;
   endproperty
   a_causes: assert property (p_causes)
      else $error("receiver not ready without local fault");

   property p_remote_pass;
      (!fault_now && rx_remote) |=> XGMII_RXD_O == $past(RX_DATA_I)
                                   && XGMII_RXC_O == $past(RX_CTRL_I);
   endproperty
   a_remote_pass: assert property (p_remote_pass)
      else $error("remote fault not forwarded unchanged");

   property p_link_down;
      (!sif.sig_ok || !blk) |=> !LINK_UP_O && !link_latch;
   endproperty
   a_link_down: assert property (p_link_down)
      else $error("link up without signal or lock");

   property p_final_code;
      fault_now |=> XGMII_RXD_O[31:24] == `FLT_CODE_LOCAL;
   endproperty
   a_final_code: assert property (p_final_code)
      else $error("local fault carries wrong sequence code");

endmodule : link_fault_signalling

// File: link_fault_signalling_test.sv
`timescale 1ns/1ps
`include "link_fault_params.svh"

module link_fault_signalling_test;
   localparam logic [31:0] IDLE_W  = 32'h07070707; // All lanes idle
   localparam logic [31:0] LF_W    = 32'h0100009C; // Local fault set
   localparam logic [31:0] RF_W    = 32'h0200009C; // Remote fault set
   localparam logic [31:0] FRAME_W = 32'hA5A5A5A5; // Partner frame word

   // Clock, reset and register bus
   logic        clk   = 1'h0;
   logic        rst_n = 1'h0;
   logic [3:0]  adr   = 4'h0;
   logic        rd    = 1'h0;
   logic        wr    = 1'h0;
   logic [31:0] wdat  = 32'h0;
   logic [3:0]  be    = 4'h0;
   logic [31:0] rdat;
   logic        wreq;
   // Receive stream and condition inputs
   logic [31:0] rxd   = IDLE_W;
   logic [3:0]  rxc   = 4'hF;
   logic        stb   = 1'h1;
   logic        hok   = 1'h1;
   logic        hiber = 1'h0;
   logic        ebuf  = 1'h0;
   logic        pins[3] = '{1'h1, 1'h1, 1'h1}; // Locked, reset done, light
   // Observed outputs
   logic [31:0] oxd;
   logic [3:0]  oxc;
   logic        lup;
   logic        lflt;
   logic        blk;
   logic        irq;
   logic [31:0] ptxd;
   logic [3:0]  ptxc;
   // Score keeping
   int          failures     = 0;
   int          total_checks = 0;

   always #5 clk = ~clk;

   // Small counts keep lock-up short
   link_fault_signalling #(.GOOD_HDRS(4), .BAD_LIMIT(2), .WINDOW(4))
      link_fault_signalling_i (.MCLK_I(clk), .RST_N_I(rst_n),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
      .RX_DATA_I(rxd), .RX_CTRL_I(rxc), .HDR_STB_I(stb), .HDR_OK_I(hok),
      .HI_BER_I(hiber), .EBUF_ERR_I(ebuf), .XCVR_LOCKED_I(pins[0]),
      .XCVR_RX_RST_DONE_I(pins[1]), .SIGNAL_DETECT_I(pins[2]),
      .XGMII_RXD_O(oxd), .XGMII_RXC_O(oxc), .LINK_UP_O(lup),
      .LOCAL_FAULT_O(lflt), .BLOCK_LOCK_O(blk), .IRQ_O(irq));

   mac_rs_model mac_rs_model_i (.clk_i(clk), .rst_n_i(rst_n), .rxd_i(oxd),
      .rxc_i(oxc), .txd_o(ptxd), .txc_o(ptxc));

   ////////////////////////////////////////////////////////////////////////
   // Verdict; the only place the run ends
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Compare and report at once
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   // One bus access; holds everything until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] e,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      adr  <= a;
      wdat <= d;
      be   <= e;
      rd   <= !w;
      wr   <= w;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'h0 && n < 50);
      q = rdat;
      // A slave that never answers ends the run
      if (n >= 50)
      begin
         failures++;
         tally_and_finish();
      end
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : bus

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d,
                         input logic [3:0] e);
      logic [31:0] q;
      bus(1'h1, a, d, e, q);
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, 4'hF, q);
      chk({4'h0, q}, {4'h0, exp});
   endtask : rd_chk

   // Bounded wait for the immediate fault indication
   task automatic wait_fault(input logic exp);
      int n;
      n = 0;
      while (lflt !== exp && n < 80)
      begin
         @(negedge clk);
         n++;
      end
      chk({35'h0, lflt}, {35'h0, exp});
      if (n >= 80)
         tally_and_finish();
   endtask : wait_fault

   // Guard against a hang anywhere
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({oxc, oxd}, {4'h1, LF_W});
      chk({33'h0, lup, lflt, irq}, 36'h2);
      @(posedge clk);
      rst_n <= 1'h1;
      $display("test reset done");

      // Lock up and look at the register map
      wait_fault(1'h0);
      chk({35'h0, lup}, 36'h1);
      @(negedge clk);
      chk({ptxc, ptxd}, {4'h0, FRAME_W});
      rd_chk(`REG_INT_MASK_OFS, 32'h0);
      rd_chk(`REG_STATUS_OFS, 32'hA9);
      rd_chk(`REG_STATUS_OFS, 32'hA3);
      rd_chk(`REG_CONTROL_OFS, 32'h0);
      rd_chk(4'h2, 32'h0);
      wr_reg(`REG_INT_MASK_OFS, 32'h7, 4'h0);
      rd_chk(`REG_INT_MASK_OFS, 32'h0);
      rd_chk(`REG_INT_STATUS_OFS, 32'h0);
      $display("test bring-up done");

      // Remote fault from the line passes through and interrupts
      wr_reg(`REG_INT_MASK_OFS, 32'h4, 4'hF);
      rd_chk(`REG_INT_MASK_OFS, 32'h4);
      @(posedge clk);
      rxd <= RF_W;
      rxc <= 4'h1;
      @(posedge clk);
      @(negedge clk);
      chk({oxc, oxd}, {4'h1, RF_W});
      @(negedge clk);
      chk({ptxc, ptxd}, {4'hF, IDLE_W});
      chk({35'h0, irq}, 36'h1);
      rd_chk(`REG_STATUS_OFS, 32'hB3);
      rd_chk(`REG_INT_STATUS_OFS, 32'h4);
      @(posedge clk);
      @(negedge clk);
      chk({35'h0, irq}, 36'h0);
      @(posedge clk);
      rxd <= IDLE_W;
      rxc <= 4'hF;
      $display("test remote fault done");

      // High error rate: local fault, masked events
      @(posedge clk);
      hiber <= 1'h1;
      wait_fault(1'h1);
      @(negedge clk);
      chk({oxc, oxd}, {4'h1, LF_W});
      chk({ptxc, ptxd}, {4'h1, RF_W});
      chk({34'h0, lup, irq}, 36'h0);
      rd_chk(`REG_STATUS_OFS, 32'hEC);
      rd_chk(`REG_INT_STATUS_OFS, 32'h3);
      @(posedge clk);
      hiber <= 1'h0;
      wait_fault(1'h0);
      wr_reg(`REG_CONTROL_OFS, 32'h3, 4'hF);
      rd_chk(`REG_STATUS_OFS, 32'hA3);
      $display("test high error rate done");

      // Elastic buffer slip is caught by the latch
      @(posedge clk);
      ebuf <= 1'h1;
      @(posedge clk);
      ebuf <= 1'h0;
      rd_chk(`REG_STATUS_OFS, 32'hAB);
      rd_chk(`REG_INT_STATUS_OFS, 32'h1);
      $display("test buffer error done");

      // Each status pin in turn; good headers keep coming meanwhile
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         pins[i] <= 1'h0;
         wait_fault(1'h1);
         repeat (8) @(negedge clk);
         chk({34'h0, lup, blk}, 36'h0);
         @(posedge clk);
         pins[i] <= 1'h1;
         wait_fault(1'h0);
      end
      $display("test status pins done");

      // Burst of bad headers drops lock
      @(posedge clk);
      hok <= 1'h0;
      repeat (3) @(posedge clk);
      hok <= 1'h1;
      wait_fault(1'h1);
      wait_fault(1'h0);
      $display("test bad headers done");

      // Soft receive reset forces a fault, then relock
      wr_reg(`REG_CONTROL_OFS, 32'h4, 4'hF);
      wait_fault(1'h1);
      wait_fault(1'h0);
      $display("test soft reset done");
      tally_and_finish();
   end
endmodule : link_fault_signalling_test

// File: mac_rs_model.sv
`timescale 1ns/1ps

module mac_rs_model
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Receive XGMII from the block
   input  wire logic [31:0] rxd_i,
   input  wire logic [3:0]  rxc_i,
   // Transmit XGMII toward the line
   output      logic [31:0] txd_o,
   output      logic [3:0]  txc_o
);
   localparam logic [31:0] IDLE_W  = 32'h07070707; // All lanes idle
   localparam logic [31:0] RF_W    = 32'h0200009C; // Remote fault set
   localparam logic [31:0] FRAME_W = 32'hA5A5A5A5; // Stand-in frame data

   // Fault set opens lane 0 with the sequence code as control
   wire logic is_seq     = rxc_i[0] && (rxd_i[7:0] == 8'h9C);
   // Final lane code separates the two kinds of fault
   wire logic got_local  = is_seq && (rxd_i[31:24] == 8'h01);
   wire logic got_remote = is_seq && (rxd_i[31:24] == 8'h02);

   ////////////////////////////////////////////////////////////////////////
   // Reaction to what arrives; queued frame data is simply dropped
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         txd_o <= IDLE_W;
         txc_o <= 4'hF;
      end
      else if (got_local)
      begin
         // Remote fault only ever as a reply to local fault
         txd_o <= RF_W;
         txc_o <= 4'h1;
      end
      else if (got_remote)
      begin
         // Idles let the partner clear its local fault
         txd_o <= IDLE_W;
         txc_o <= 4'hF;
      end
      else
      begin
         // Healthy receive side: frames flow again
         txd_o <= FRAME_W;
         txc_o <= 4'h0;
      end
   end
endmodule : mac_rs_model

// File: sync_if.sv
`timescale 1ns/1ps

interface sync_if;
   logic                   hdr_stb;     // One sync header checked
   logic                   hdr_ok;      // That header was valid
   logic                   sig_ok;      // Signal present, no reset
   logic                   block_lock;  // Synchronised to blocks
   fault_pkg::sync_state_e state;       // Current sync state

   // Side that feeds headers and watches the lock
   modport ctrl (output hdr_stb, hdr_ok, sig_ok,
                 input  block_lock, state);
   // Side that runs the synchronisation machine
   modport fsm  (input  hdr_stb, hdr_ok, sig_ok,
                 output block_lock, state);
endinterface : sync_if
